//--- core/dsm_defs.vh
// Purpose: constants for the signal mixer (register map, fields, codes)
// Assumes: Avalon-MM slave, 32-bit words, 8-bit registers in low bits
// Notes:   byte addresses are word aligned
`ifndef DSM_DEFS_VH
`define DSM_DEFS_VH

// ********************************
// register byte addresses
// ********************************
`define DSM_ADDR_MOD_CTRL    4'h0
`define DSM_ADDR_CAR_CTRL    4'h4
`define DSM_ADDR_MOD_SRC     4'h8
`define DSM_ADDR_HCAR_SEL    4'hC
`define DSM_ADDR_LCAR_SEL    4'h0
`define DSM_ADDR_LCAR_PAGE   1'b1

// ********************************
// field positions
// ********************************
`define DSM_BIT_ENABLE       7
`define DSM_BIT_OUT_STATUS   5
`define DSM_BIT_OUT_POL      4
`define DSM_BIT_SW_DATA      0
`define DSM_BIT_HCAR_POL     5
`define DSM_BIT_HCAR_SYNC    4
`define DSM_BIT_LCAR_POL     1
`define DSM_BIT_LCAR_SYNC    0

// ********************************
// reset values and widths
// ********************************
`define DSM_MOD_CTRL_RST     8'h00
`define DSM_CAR_CTRL_RST     8'h00
`define DSM_MOD_SRC_RST      5'h00
`define DSM_CAR_SEL_RST      4'h0
`define DSM_MOD_CTRL_WMASK   8'h91
`define DSM_CAR_CTRL_WMASK   8'h33
`define DSM_ZERO32           32'h0000_0000

// ********************************
// source codes
// ********************************
`define DSM_MS_PIN           5'h00
`define DSM_MS_SWBIT         5'h01
`define DSM_MS_LAST          5'h13
`define DSM_MS_COUNT         20
`define DSM_CS_COUNT         16

`endif

//--- core/dsm_edge_sync.v
// Purpose: registers an asynchronous-looking input and flags falling edges
// Assumes: input already synchronous to CLOCK_I
// Notes:   one flop of delay; fall is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module dsm_edge_sync (
    // clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // signal
    input  wire sig_i,
    output reg  sig_o,
    output wire fall_o
);
    reg prev_reg;

    // sample and keep last value for edge detection
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sig_o    <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sig_o    <= sig_i;
            prev_reg <= sig_o;
        end
    end

    assign fall_o = prev_reg & ~sig_o;
endmodule
`default_nettype wire

//--- core/dsm_carrier_mux.v
// Purpose: picks one of sixteen carrier sources and applies polarity
// Assumes: code 0 is the routed pin, 1 system clock, 2 fast osc, 3 ref clk
// Notes:   disabled mixer forces the carrier low
`timescale 1ns/100ps
`default_nettype none
module dsm_carrier_mux (
    // selection
    input  wire [3:0]  code_i,
    input  wire        invert_i,
    input  wire        enable_i,
    // sources
    input  wire [15:0] src_i,
    // result
    output wire        car_o
);
    // polarity after selection, ground when disabled
    assign car_o = enable_i & (src_i[code_i] ^ invert_i);
endmodule
`default_nettype wire

//--- core/dsm_top.v
// Purpose: data signal mixer with Avalon-MM register access
// Assumes: one 40 MHz clock, all source inputs synchronous to it
// Notes:   output pin and status bit come from flip-flops
//
// Contract
// - enable bit seven mixes; clear means no output
// - status bit five shows current modulated output
// - polarity bit four inverts output, idles high
// - software bit used only with source code one; the code also makes it the modulator whenever disabled
// - high carrier polarity bit inverts high carrier
// - high sync waits high carrier falling edge
// - low carrier polarity bit inverts low carrier
// - low sync waits low carrier falling edge
// - five-bit source select; zero selects routed pin
// - codes two to six select PWM units
// - codes seven to eleven: PWM, oscillator, comparators
// - codes twelve to seventeen: logic cells, serial lines
// - eighteen, nineteen sync serial; above connects nothing
// - high carrier codes zero to three: pin, clocks
// - high carrier codes four to eight: PWM units
// - high carrier nine to fifteen: PWM, oscillator, cells
// - unimplemented register bits read as zero
// - output is enable AND active carrier
// - disabled forces carriers low, software bit modulates
// - low carrier selector uses same encoding
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dsm_defs.vh"
module dsm_top (
    // clock and reset
    input  wire        CLOCK_I,
    input  wire        RESETN_I,
    // avalon-mm slave
    input  wire [4:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    output reg  [31:0] AVS_READDATA_O,
    output reg         AVS_WAITREQUEST_O,
    output reg  [1:0]  AVS_RESPONSE_O,
    // routed input pins
    input  wire        MOD_PIN_I,
    input  wire        HCAR_PIN_I,
    input  wire        LCAR_PIN_I,
    // on-chip sources
    input  wire        SYS_CLK_SIG_I,
    input  wire        FAST_OSC_I,
    input  wire        REF_CLK_I,
    input  wire [4:0]  PWM_UNIT_I,
    input  wire [1:0]  PWM_EXTRA_I,
    input  wire        NUM_OSC_I,
    input  wire [1:0]  COMPARATOR_I,
    input  wire [3:0]  LOGIC_CELL_I,
    input  wire        ASYNC_DT_I,
    input  wire        ASYNC_TXCK_I,
    input  wire [1:0]  SYNC_SDO_I,
    // modulated output
    output reg         MOD_OUT_O
);
    // ********************************
    // registers
    // ********************************
    reg       enable_reg;
    reg       out_pol_reg;
    reg       sw_bit_reg;
    reg       hcar_pol_reg;
    reg       hcar_sync_reg;
    reg       lcar_pol_reg;
    reg       lcar_sync_reg;
    reg [4:0] mod_code_reg;
    reg [3:0] hcar_code_reg;
    reg [3:0] lcar_code_reg;
    reg       status_reg;
    reg       use_high_reg;
    reg       use_high_next;
    reg       ack_reg;
    reg [7:0] rd_byte;
    reg       hit;

    wire        wr_lo = AVS_BYTEENABLE_I[0];
    wire        req   = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
    wire        pin_mod;
    wire        pin_h;
    wire        pin_l;
    wire        fall_h;
    wire        fall_l;
    wire        car_h;
    wire        car_l;
    wire [31:0] mod_src;
    wire [15:0] car_src_h;
    wire [15:0] car_src_l;

    // ********************************
    // input pin registers
    // ********************************
    dsm_edge_sync u_mod_pin (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .sig_i   (MOD_PIN_I),
        .sig_o   (pin_mod),
        .fall_o  ()
    );
    dsm_edge_sync u_hcar_pin (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .sig_i   (HCAR_PIN_I),
        .sig_o   (pin_h),
        .fall_o  ()
    );
    dsm_edge_sync u_lcar_pin (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .sig_i   (LCAR_PIN_I),
        .sig_o   (pin_l),
        .fall_o  ()
    );

    // ********************************
    // source tables
    // ********************************
    // modulator sources; codes from twenty upward read zero
    assign mod_src = {12'h000,
                      SYNC_SDO_I,
                      ASYNC_TXCK_I, ASYNC_DT_I,
                      LOGIC_CELL_I,
                      COMPARATOR_I, NUM_OSC_I,
                      PWM_EXTRA_I,
                      PWM_UNIT_I,
                      sw_bit_reg, pin_mod};

    // carrier sources share one encoding, code zero differs
    assign car_src_h = {LOGIC_CELL_I, NUM_OSC_I, PWM_EXTRA_I,
                        PWM_UNIT_I,
                        REF_CLK_I, FAST_OSC_I, SYS_CLK_SIG_I,
                        pin_h};
    assign car_src_l = {car_src_h[15:1], pin_l};

    dsm_carrier_mux u_hcar (
        .code_i   (hcar_code_reg),
        .invert_i (hcar_pol_reg),
        .enable_i (enable_reg),
        .src_i    (car_src_h),
        .car_o    (car_h)
    );
    dsm_carrier_mux u_lcar (
        .code_i   (lcar_code_reg),
        .invert_i (lcar_pol_reg),
        .enable_i (enable_reg),
        .src_i    (car_src_l),
        .car_o    (car_l)
    );

    // carrier falling edges for the sync waits
    dsm_edge_sync u_hfall (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .sig_i   (car_h),
        .sig_o   (),
        .fall_o  (fall_h)
    );
    dsm_edge_sync u_lfall (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .sig_i   (car_l),
        .sig_o   (),
        .fall_o  (fall_l)
    );

    // ********************************
    // mixing
    // ********************************
    // disabled: software bit is the modulator whatever the code
    wire mod_sig = enable_reg ? mod_src[mod_code_reg] : sw_bit_reg;

    // carrier switchover, optionally held until a falling edge
    always @* begin
        use_high_next = use_high_reg;
        if (mod_sig && !use_high_reg) begin
            if (!lcar_sync_reg || fall_l || !car_l) begin
                use_high_next = 1'b1;
            end
        end else if (!mod_sig && use_high_reg) begin
            if (!hcar_sync_reg || fall_h || !car_h) begin
                use_high_next = 1'b0;
            end
        end
    end

    // modulator high passes the high carrier, low passes the low carrier;
    // during a sync wait the old carrier stays, so no pulse is cut short
    wire active_car = use_high_next ? car_h : car_l;
    wire mixed      = enable_reg & active_car;
    wire pin_level  = mixed ^ out_pol_reg;

    always @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            use_high_reg <= 1'b0;
            MOD_OUT_O    <= 1'b0;
            status_reg   <= 1'b0;
        end else begin
            use_high_reg <= use_high_next;
            MOD_OUT_O    <= pin_level;
            status_reg   <= pin_level;
        end
    end

    // ********************************
    // register read mux
    // ********************************
    always @* begin
        rd_byte = 8'h00;
        hit     = 1'b1;
        case (AVS_ADDRESS_I)
            {1'b0, `DSM_ADDR_MOD_CTRL}: begin
                rd_byte[`DSM_BIT_ENABLE]     = enable_reg;
                rd_byte[`DSM_BIT_OUT_STATUS] = status_reg;
                rd_byte[`DSM_BIT_OUT_POL]    = out_pol_reg;
                rd_byte[`DSM_BIT_SW_DATA]    = sw_bit_reg;
            end
            {1'b0, `DSM_ADDR_CAR_CTRL}: begin
                rd_byte[`DSM_BIT_HCAR_POL]  = hcar_pol_reg;
                rd_byte[`DSM_BIT_HCAR_SYNC] = hcar_sync_reg;
                rd_byte[`DSM_BIT_LCAR_POL]  = lcar_pol_reg;
                rd_byte[`DSM_BIT_LCAR_SYNC] = lcar_sync_reg;
            end
            {1'b0, `DSM_ADDR_MOD_SRC}:  rd_byte = {3'b000, mod_code_reg};
            {1'b0, `DSM_ADDR_HCAR_SEL}: rd_byte = {4'h0, hcar_code_reg};
            {`DSM_ADDR_LCAR_PAGE, `DSM_ADDR_LCAR_SEL}:
                rd_byte = {4'h0, lcar_code_reg};
            default: hit = 1'b0;
        endcase
    end

    // ********************************
    // avalon slave: one wait state, then acknowledge
    // ********************************
    // registered answer keeps readdata and waitrequest flop-driven
    always @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            ack_reg           <= 1'b0;
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= `DSM_ZERO32;
            AVS_RESPONSE_O    <= 2'b00;
        end else begin
            ack_reg           <= req;
            AVS_WAITREQUEST_O <= ~req;
            if (req) begin
                AVS_READDATA_O <= AVS_READ_I ? {24'h000000, rd_byte} : `DSM_ZERO32;
                AVS_RESPONSE_O <= hit ? 2'b00 : 2'b11;
            end
        end
    end

    // register writes land on the edge the request is accepted
    always @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            enable_reg    <= 1'b0;
            out_pol_reg   <= 1'b0;
            sw_bit_reg    <= 1'b0;
            hcar_pol_reg  <= 1'b0;
            hcar_sync_reg <= 1'b0;
            lcar_pol_reg  <= 1'b0;
            lcar_sync_reg <= 1'b0;
            mod_code_reg  <= `DSM_MOD_SRC_RST;
            hcar_code_reg <= `DSM_CAR_SEL_RST;
            lcar_code_reg <= `DSM_CAR_SEL_RST;
        end else if (ack_reg && AVS_WRITE_I && wr_lo) begin
            case (AVS_ADDRESS_I)
                {1'b0, `DSM_ADDR_MOD_CTRL}: begin
                    enable_reg  <= AVS_WRITEDATA_I[`DSM_BIT_ENABLE];
                    out_pol_reg <= AVS_WRITEDATA_I[`DSM_BIT_OUT_POL];
                    sw_bit_reg  <= AVS_WRITEDATA_I[`DSM_BIT_SW_DATA];
                end
                {1'b0, `DSM_ADDR_CAR_CTRL}: begin
                    hcar_pol_reg  <= AVS_WRITEDATA_I[`DSM_BIT_HCAR_POL];
                    hcar_sync_reg <= AVS_WRITEDATA_I[`DSM_BIT_HCAR_SYNC];
                    lcar_pol_reg  <= AVS_WRITEDATA_I[`DSM_BIT_LCAR_POL];
                    lcar_sync_reg <= AVS_WRITEDATA_I[`DSM_BIT_LCAR_SYNC];
                end
                {1'b0, `DSM_ADDR_MOD_SRC}:  mod_code_reg  <= AVS_WRITEDATA_I[4:0];
                {1'b0, `DSM_ADDR_HCAR_SEL}: hcar_code_reg <= AVS_WRITEDATA_I[3:0];
                {`DSM_ADDR_LCAR_PAGE, `DSM_ADDR_LCAR_SEL}:
                    lcar_code_reg <= AVS_WRITEDATA_I[3:0];
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- test/mix_src_model.sv
// Purpose: on-chip sources and routed pins that feed the mixer
// Assumes: bench hands over one level per source line
// Notes:   levels move just after a rising edge, like real peripherals
`timescale 1ns/100ps
`default_nettype none
module mix_src_model (
    // clock
    input  wire logic        clk_i,
    // requested levels, pins in bits 2:0
    input  wire logic [23:0] lvl_i,
    // source lines
    output var  logic [23:0] src_o
);
    // ****************************************
    // source registers
    // ****************************************
    // known level from time zero, so no input floats
    initial begin
        src_o = 24'h000000;
    end
    // registered so no source edge lands on a sampling edge
    always @(posedge clk_i) begin
        src_o <= lvl_i;
    end
endmodule
`default_nettype wire

//--- test/mix_props.sv
// Purpose: port-level checks for the signal mixer
// Assumes: a write lands at the edge that sees waitrequest low
// Notes:   shadow registers; pin codes and sync left to the bench
`timescale 1ns/100ps
`default_nettype none
module mix_props (
    // bus
    input wire logic        CLOCK_I, RESETN_I, AVS_READ_I, AVS_WRITE_I,
    input wire logic [4:0]  AVS_ADDRESS_I,
    input wire logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O,
    input wire logic [3:0]  AVS_BYTEENABLE_I, LOGIC_CELL_I,
    input wire logic        AVS_WAITREQUEST_O, MOD_OUT_O,
    input wire logic [1:0]  AVS_RESPONSE_O, PWM_EXTRA_I, COMPARATOR_I, SYNC_SDO_I,
    // sources
    input wire logic        MOD_PIN_I, HCAR_PIN_I, LCAR_PIN_I, SYS_CLK_SIG_I, FAST_OSC_I,
    input wire logic        REF_CLK_I, NUM_OSC_I, ASYNC_DT_I, ASYNC_TXCK_I,
    input wire logic [4:0]  PWM_UNIT_I
);
    // ****************************************
    // shadow registers and expected mix
    // ****************************************
    logic [7:0] c0, c1;
    logic [4:0] ms;
    logic [3:0] hs, ls;
    logic [1:0] quiet;
    wire ack = !AVS_WAITREQUEST_O;
    wire acc = AVS_WRITE_I && ack && AVS_BYTEENABLE_I[0];
    wire [19:0] mv = {SYNC_SDO_I, ASYNC_TXCK_I, ASYNC_DT_I, LOGIC_CELL_I, COMPARATOR_I,
                      NUM_OSC_I, PWM_EXTRA_I, PWM_UNIT_I, c0[0], MOD_PIN_I};
    wire [14:0] cv = {LOGIC_CELL_I, NUM_OSC_I, PWM_EXTRA_I, PWM_UNIT_I, REF_CLK_I,
                      FAST_OSC_I, SYS_CLK_SIG_I};
    wire [15:0] hv = {cv, HCAR_PIN_I};
    wire [15:0] lv = {cv, LCAR_PIN_I};
    wire md = (ms < 5'h14) && mv[ms];
    wire mix = c0[4] ^ (c0[7] & (md ? hv[hs] ^ c1[5] : lv[ls] ^ c1[1]));
    // pin paths and sync waits have their own timing, so left out here
    wire calm = quiet == 2'h3 && (!c0[7] || (ms != 5'h00 && hs != 4'h0 && ls != 4'h0
                && c1[4] == 1'b0 && c1[0] == 1'b0));
    wire [7:0] rmask = AVS_ADDRESS_I == 5'h00 ? 8'hB1 : AVS_ADDRESS_I == 5'h04 ? 8'h33 :
                       AVS_ADDRESS_I == 5'h08 ? 8'h1F : 8'h0F;
    // quiet counts cycles since the last accepted write
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            c0 <= 8'h00;
            c1 <= 8'h00;
            ms <= 5'h00;
            hs <= 4'h0;
            ls <= 4'h0;
            quiet <= 2'h0;
        end else begin
            quiet <= acc ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
            if (acc) begin
                case (AVS_ADDRESS_I)
                    5'h00: c0 <= AVS_WRITEDATA_I[7:0] & 8'h91;
                    5'h04: c1 <= AVS_WRITEDATA_I[7:0] & 8'h33;
                    5'h08: ms <= AVS_WRITEDATA_I[4:0];
                    5'h0C: hs <= AVS_WRITEDATA_I[3:0];
                    5'h10: ls <= AVS_WRITEDATA_I[3:0];
                    default: ;
                endcase
            end
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    a_req_answered: assert property ((AVS_READ_I || AVS_WRITE_I) && !ack |=> ack)
        else $error("request not answered in the next cycle");
    a_ack_single: assert property (ack |=> !ack)
        else $error("waitrequest low for more than one cycle");
    a_idle_no_ack: assert property (!(AVS_READ_I || AVS_WRITE_I) |=> !ack)
        else $error("answer without a request");
    a_upper_zero: assert property (ack && AVS_READ_I |-> AVS_READDATA_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unimpl_zero: assert property (ack && AVS_READ_I && AVS_RESPONSE_O == 2'b00
        |-> (AVS_READDATA_O[7:0] & ~rmask) == 8'h00) else $error("unimplemented bit reads one");
    a_resp_code: assert property (ack && AVS_ADDRESS_I[1:0] == 2'b00
        |-> AVS_RESPONSE_O == (AVS_ADDRESS_I > 5'h10 ? 2'b11 : 2'b00)) else $error("bad response");
    a_status_mirror: assert property (ack && AVS_READ_I && AVS_ADDRESS_I == 5'h00
        && $stable(MOD_OUT_O) |-> AVS_READDATA_O[5] == MOD_OUT_O) else $error("status differs");
    a_mix_output: assert property (calm |-> MOD_OUT_O == $past(mix))
        else $error("modulated output differs from expected mix");
    a_disabled_idle: assert property (quiet == 2'h3 && !c0[7]
        |-> MOD_OUT_O == c0[4] ##1 MOD_OUT_O == $past(c0[4])) else $error("disabled output");
    c_unmapped: cover property (ack && AVS_RESPONSE_O == 2'b11);
    c_mix_high: cover property (calm && c0[7] && MOD_OUT_O);
    c_sync_hold: cover property (c0[7] && c1[4] && MOD_OUT_O && !md);
endmodule
bind dsm_top mix_props u_props (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .LOGIC_CELL_I(LOGIC_CELL_I),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .MOD_OUT_O(MOD_OUT_O),
    .AVS_RESPONSE_O(AVS_RESPONSE_O), .PWM_EXTRA_I(PWM_EXTRA_I), .COMPARATOR_I(COMPARATOR_I),
    .SYNC_SDO_I(SYNC_SDO_I), .MOD_PIN_I(MOD_PIN_I), .HCAR_PIN_I(HCAR_PIN_I),
    .LCAR_PIN_I(LCAR_PIN_I), .SYS_CLK_SIG_I(SYS_CLK_SIG_I), .FAST_OSC_I(FAST_OSC_I),
    .REF_CLK_I(REF_CLK_I), .NUM_OSC_I(NUM_OSC_I), .ASYNC_DT_I(ASYNC_DT_I),
    .ASYNC_TXCK_I(ASYNC_TXCK_I), .PWM_UNIT_I(PWM_UNIT_I));
`default_nettype wire

//--- test/mix_bench.sv
// Purpose: register-driven test of the signal mixer
// Assumes: sources come from the model, levels held steady per case
// Notes:   outputs compared only after a few settling cycles
`timescale 1ns/100ps
`default_nettype none
module mix_bench;
    logic clk, rst_n, rd, wr, mout, wreq;
    logic [4:0] adr, ms;
    logic [31:0] wdat, rdata, q;
    logic [3:0] ben, c;
    logic [1:0] resp;
    logic [23:0] lvl, src, v;
    int error_cnt, cmp_count;
    // ****************************************
    // clock, design and sources
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    dsm_top u_dut (.CLOCK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(ben),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_O(resp),
        .MOD_PIN_I(src[0]), .HCAR_PIN_I(src[1]), .LCAR_PIN_I(src[2]), .SYS_CLK_SIG_I(src[3]),
        .FAST_OSC_I(src[4]), .REF_CLK_I(src[5]), .PWM_UNIT_I(src[10:6]),
        .PWM_EXTRA_I(src[12:11]), .NUM_OSC_I(src[13]), .COMPARATOR_I(src[15:14]),
        .LOGIC_CELL_I(src[19:16]), .ASYNC_DT_I(src[20]), .ASYNC_TXCK_I(src[21]),
        .SYNC_SDO_I(src[23:22]), .MOD_OUT_O(mout));
    mix_src_model u_src (.clk_i(clk), .lvl_i(lvl), .src_o(src));
    // counts every compare; a mismatch is printed at once
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one bus transfer; held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                        input logic [3:0] be);
        int n;
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        ben <= be;
        wr <= w;
        rd <= ~w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // a bus that never answers ends the run through the report
        if (wreq !== 1'b0) begin
            error_cnt++;
            results();
        end
    endtask
    // steady levels only: the status bit is not trusted for fast signals
    task automatic settle(input logic e);
        repeat (4) @(posedge clk);
        check({31'h0, mout}, {31'h0, e});
        xfer(1'b0, 5'h00, 8'h00, 4'h1);
        check({31'h0, q[5]}, {31'h0, e});
    endtask
    // control register last, so the mix starts from a full setup
    task automatic run(input logic [7:0] c0, c1, input logic [4:0] m,
                       input logic [3:0] hs, ls, input logic [23:0] l, input logic e);
        lvl <= l;
        xfer(1'b1, 5'h04, c1, 4'h1);
        xfer(1'b1, 5'h08, {3'h0, m}, 4'h1);
        xfer(1'b1, 5'h0C, {4'h0, hs}, 4'h1);
        xfer(1'b1, 5'h10, {4'h0, ls}, 4'h1);
        xfer(1'b1, 5'h00, c0, 4'h1);
        settle(e);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 5'h00;
        wdat = 32'h0;
        ben = 4'h0;
        lvl = 24'h0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 5'(i * 4), 8'h00, 4'h1);
            check(q, 32'h0);
        end
        for (int i = 1; i < 5; i++) begin
            xfer(1'b1, 5'(i * 4), 8'hFF, 4'h1);
            xfer(1'b0, 5'(i * 4), 8'h00, 4'h1);
            check(q, i == 1 ? 32'h33 : (i == 2 ? 32'h1F : 32'h0F));
        end
        xfer(1'b1, 5'h04, 8'h00, 4'h0);
        xfer(1'b0, 5'h04, 8'h00, 4'h1);
        check(q, 32'h33);
        xfer(1'b1, 5'h14, 8'hFF, 4'h1);
        check({30'h0, resp}, 32'h3);
        xfer(1'b0, 5'h18, 8'h00, 4'h1);
        check(q, 32'h0);
        for (int m = 0; m < 22; m++) begin
            v = (m == 1 || m > 19) ? 24'h0 : 24'h1 << (m == 0 ? 0 : m + 4);
            ms = m == 21 ? 5'h1F : 5'(m);
            run(8'h80 | 8'(m == 1), 8'h00, ms, 4'h1, 4'h2, (v & ~24'h18) | 24'h08, m < 20);
            run(8'h80 | 8'(m != 1), 8'h00, ms, 4'h1, 4'h2, (~v & ~24'h18) | 24'h08, 1'b0);
        end
        for (int k = 0; k < 32; k++) begin
            c = k[3:0];
            v = 24'h1 << (c == 4'h0 ? 1 + k / 16 : (c < 4'hC ? c + 2 : c + 4));
            run(k < 16 ? 8'h81 : 8'h80, 8'h00, 5'h01, c, c, v, 1'b1);
            run(k < 16 ? 8'h81 : 8'h80, 8'h00, 5'h01, c, c, ~v, 1'b0);
        end
        for (int p = 0; p < 16; p++) begin
            run({3'b100, p[1], 3'b000, p[0]}, {2'b00, p[2], 3'b000, p[3], 1'b0}, 5'h01,
                4'h1, 4'h2, 24'h08, p[1] ^ (p[0] ? ~p[2] : p[3]));
        end
        for (int p = 0; p < 2; p++) begin
            run({3'b000, p[0], 4'h1}, 8'h00, 5'h01, 4'h1, 4'h1, 24'hFFFFFF, p[0]);
            xfer(1'b0, 5'h0C, 8'h00, 4'h1);
            check(q, 32'h1);
        end
        run(8'h81, 8'h10, 5'h01, 4'h1, 4'h2, 24'h08, 1'b1);
        xfer(1'b1, 5'h00, 8'h80, 4'h1);
        settle(1'b1);
        lvl <= 24'h0;
        settle(1'b0);
        run(8'h80, 8'h01, 5'h01, 4'h1, 4'h2, 24'h10, 1'b1);
        xfer(1'b1, 5'h00, 8'h81, 4'h1);
        settle(1'b1);
        lvl <= 24'h0;
        settle(1'b0);
        results();
    end
endmodule
`default_nettype wire
